// ===== hw/ctrb_pkg.sv
`default_nettype none
package ctrb_pkg;

  // Register port geometry
  localparam int          CTRB_ADDR_W   = 12;
  localparam int          CTRB_DATA_W   = 16;
  localparam int          CTRB_TIME_W   = 8;
  localparam int          CTRB_OFS_W    = 12;

  // Register offsets
  localparam logic [11:0] CTRB_OFS_TIME_B_SGL_B = 12'h31B;
  localparam logic [11:0] CTRB_OFS_OFS_A_DUAL_A = 12'h344;
  localparam logic [11:0] CTRB_OFS_OFS_A_DUAL_B = 12'h346;
  localparam logic [11:0] CTRB_OFS_OFS_A_SGL_A  = 12'h348;
  localparam logic [11:0] CTRB_OFS_OFS_A_SGL_B  = 12'h34A;

  // Field layout of the offset trims
  localparam int          CTRB_OFS_FIELD_MSB = 11;
  localparam int          CTRB_RSV_LSB       = 12;
  localparam int          CTRB_RSV_MSB       = 15;

  // Values after reset, before the fuse load
  localparam logic [7:0]  CTRB_RST_TIME = 8'h00;
  localparam logic [15:0] CTRB_RST_OFS  = 16'h0000;
  localparam logic [15:0] CTRB_RD_NONE  = 16'h0000;

  // Load sequencing
  typedef enum logic {
    st_load,
    st_run
  } ctrb_state_t;

endpackage
`default_nettype wire

// ===== hw/ctrb_top.sv
// Functional notes
// - Core B time trim 0x31B: single mode, calibration on, input B.
// - Core A offset 0x344: dual mode, input A, calibration on.
// - Core A offset 0x346: dual mode, input B, 0-degree phase, calibration on.
// - Core A offset 0x348: single mode, input A, calibration on.
// - Core A offset 0x34A: input B, 90-degree phase, calibration on.
// - Offset bits 15:12 are writable, reset to zero, never applied.
// - After power-up every trim is loaded from the fuse defaults.
// - Timing trims read back, may be overwritten, and move the sample.
//
// The plain strobed port is this design's own decision.
`default_nettype none
module ctrb_top
  import ctrb_pkg::*;
(
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_reset,
  // Register port
  input  wire logic [CTRB_ADDR_W-1:0] i_addr,
  input  wire logic [CTRB_DATA_W-1:0] i_wdata,
  input  wire logic                   i_write,
  input  wire logic                   i_read,
  output logic      [CTRB_DATA_W-1:0] o_rdata,
  // Fuse defaults
  input  wire logic                   i_fuse_valid,
  input  wire logic [CTRB_TIME_W-1:0] i_fuse_time_b_sgl_b,
  input  wire logic [CTRB_DATA_W-1:0] i_fuse_ofs_a_dual_a,
  input  wire logic [CTRB_DATA_W-1:0] i_fuse_ofs_a_dual_b,
  input  wire logic [CTRB_DATA_W-1:0] i_fuse_ofs_a_sgl_a,
  input  wire logic [CTRB_DATA_W-1:0] i_fuse_ofs_a_sgl_b,
  // Converter mode
  input  wire logic                   i_fg_cal_en,
  input  wire logic                   i_single_mode,
  input  wire logic                   i_second_analog_input,
  input  wire logic                   i_phase_90,
  // Applied trims
  output logic      [CTRB_TIME_W-1:0] o_time_trim,
  output logic                        o_time_trim_en,
  output logic      [CTRB_OFS_W-1:0]  o_offset_trim,
  output logic                        o_offset_trim_en,
  output logic                        o_loaded
);

  ctrb_state_t                state;
  logic [CTRB_TIME_W-1:0]     core_b_single_input_b_time_trim;
  logic [CTRB_DATA_W-1:0]     core_a_dual_input_a_offset_trim;
  logic [CTRB_DATA_W-1:0]     core_a_dual_input_b_offset_trim;
  logic [CTRB_DATA_W-1:0]     core_a_single_input_a_offset_trim;
  logic [CTRB_DATA_W-1:0]     core_a_single_input_b_offset_trim;

  wire                        running;
  wire                        wr_ok;
  wire                        hit_time;
  wire                        hit_dual_a;
  wire                        hit_dual_b;
  wire                        hit_sgl_a;
  wire                        hit_sgl_b;
  wire                        sel_time;
  wire                        sel_dual_a;
  wire                        sel_dual_b;
  wire                        sel_sgl_a;
  wire                        sel_sgl_b;
  wire                        sel_any_ofs;
  wire [CTRB_DATA_W-1:0]      rd_mux;
  wire [CTRB_DATA_W-1:0]      ofs_mux;

  // Writes wait for the fuse load so defaults never clobber software values
  assign running    = (state == st_run);
  assign wr_ok      = i_write & running;
  assign hit_time   = (i_addr == CTRB_OFS_TIME_B_SGL_B);
  assign hit_dual_a = (i_addr == CTRB_OFS_OFS_A_DUAL_A);
  assign hit_dual_b = (i_addr == CTRB_OFS_OFS_A_DUAL_B);
  assign hit_sgl_a  = (i_addr == CTRB_OFS_OFS_A_SGL_A);
  assign hit_sgl_b  = (i_addr == CTRB_OFS_OFS_A_SGL_B);

  assign sel_time   = running & i_fg_cal_en & i_single_mode
                      & i_second_analog_input;
  assign sel_dual_a = running & i_fg_cal_en & ~i_single_mode
                      & ~i_second_analog_input;
  // dual input B, phase 90 takes precedence
  assign sel_dual_b = running & i_fg_cal_en & ~i_single_mode
                      & i_second_analog_input & ~i_phase_90;
  assign sel_sgl_a  = running & i_fg_cal_en & i_single_mode
                      & ~i_second_analog_input;
  assign sel_sgl_b  = running & i_fg_cal_en & i_second_analog_input
                      & i_phase_90;
  assign sel_any_ofs = sel_dual_a | sel_dual_b | sel_sgl_a | sel_sgl_b;

  assign ofs_mux = sel_dual_a ? core_a_dual_input_a_offset_trim   :
                   sel_dual_b ? core_a_dual_input_b_offset_trim   :
                   sel_sgl_a  ? core_a_single_input_a_offset_trim :
                   sel_sgl_b  ? core_a_single_input_b_offset_trim :
                                CTRB_RST_OFS;

  // plain read back, unmapped reads zero
  assign rd_mux = hit_time   ? {8'h00, core_b_single_input_b_time_trim} :
                  hit_dual_a ? core_a_dual_input_a_offset_trim   :
                  hit_dual_b ? core_a_dual_input_b_offset_trim   :
                  hit_sgl_a  ? core_a_single_input_a_offset_trim :
                  hit_sgl_b  ? core_a_single_input_b_offset_trim :
                               CTRB_RD_NONE;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state <= st_load;
    end else if (i_fuse_valid) begin
      state <= st_run;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      core_b_single_input_b_time_trim <= CTRB_RST_TIME;
    end else if (!running && i_fuse_valid) begin
      core_b_single_input_b_time_trim <= i_fuse_time_b_sgl_b;
    end else if (wr_ok && hit_time) begin
      core_b_single_input_b_time_trim <= i_wdata[CTRB_TIME_W-1:0];
    end
  end

  // full 16 bits stored, reserved nibble included
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      core_a_dual_input_a_offset_trim   <= CTRB_RST_OFS;
      core_a_dual_input_b_offset_trim   <= CTRB_RST_OFS;
      core_a_single_input_a_offset_trim <= CTRB_RST_OFS;
      core_a_single_input_b_offset_trim <= CTRB_RST_OFS;
    end else if (!running && i_fuse_valid) begin
      core_a_dual_input_a_offset_trim   <= i_fuse_ofs_a_dual_a;
      core_a_dual_input_b_offset_trim   <= i_fuse_ofs_a_dual_b;
      core_a_single_input_a_offset_trim <= i_fuse_ofs_a_sgl_a;
      core_a_single_input_b_offset_trim <= i_fuse_ofs_a_sgl_b;
    end else if (wr_ok) begin
      if (hit_dual_a) begin
        core_a_dual_input_a_offset_trim <= i_wdata;
      end
      if (hit_dual_b) begin
        core_a_dual_input_b_offset_trim <= i_wdata;
      end
      if (hit_sgl_a) begin
        core_a_single_input_a_offset_trim <= i_wdata;
      end
      if (hit_sgl_b) begin
        core_a_single_input_b_offset_trim <= i_wdata;
      end
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rdata <= CTRB_RD_NONE;
    end else begin
      o_rdata <= i_read ? rd_mux : CTRB_RD_NONE;
    end
  end

  // only bits 11:0 reach the converter
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_time_trim      <= CTRB_RST_TIME;
      o_time_trim_en   <= 1'b0;
      o_offset_trim    <= CTRB_RST_OFS[CTRB_OFS_FIELD_MSB:0];
      o_offset_trim_en <= 1'b0;
      o_loaded         <= 1'b0;
    end else begin
      o_time_trim      <= core_b_single_input_b_time_trim;
      o_time_trim_en   <= sel_time;
      o_offset_trim    <= ofs_mux[CTRB_OFS_FIELD_MSB:0];
      o_offset_trim_en <= sel_any_ofs;
      o_loaded         <= running;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  chk_time_trim_sel: assert property (
    sel_time |=> o_time_trim_en &&
      o_time_trim == $past(core_b_single_input_b_time_trim))
    else $error("time trim not applied");
  chk_dual_a_sel: assert property (
    sel_dual_a |=> o_offset_trim_en &&
      o_offset_trim == $past(core_a_dual_input_a_offset_trim[11:0]))
    else $error("dual input A offset wrong");
  chk_dual_b_sel: assert property (
    sel_dual_b |=> o_offset_trim_en &&
      o_offset_trim == $past(core_a_dual_input_b_offset_trim[11:0]))
    else $error("dual input B offset wrong");
  chk_single_a_sel: assert property (
    sel_sgl_a |=> o_offset_trim_en &&
      o_offset_trim == $past(core_a_single_input_a_offset_trim[11:0]))
    else $error("single input A offset wrong");
  chk_phase90_b_sel: assert property (
    sel_sgl_b |=> o_offset_trim_en &&
      o_offset_trim == $past(core_a_single_input_b_offset_trim[11:0]))
    else $error("phase 90 input B offset wrong");
  chk_reserved_kept: assert property (
    (wr_ok && hit_dual_a) ##1 (i_read && hit_dual_a && !i_write)
      |=> o_rdata[CTRB_RSV_MSB:CTRB_RSV_LSB] ==
          $past(i_wdata[CTRB_RSV_MSB:CTRB_RSV_LSB], 2))
    else $error("reserved bits not kept");
  chk_fuse_load: assert property (
    (!running && i_fuse_valid) |=> running &&
      core_b_single_input_b_time_trim == $past(i_fuse_time_b_sgl_b) &&
      core_a_single_input_b_offset_trim == $past(i_fuse_ofs_a_sgl_b))
    else $error("fuse defaults not loaded");
  chk_time_write: assert property (
    (wr_ok && hit_time) ##1 !i_write
      |=> o_time_trim == $past(i_wdata[7:0], 2))
    else $error("written time trim not applied");
  chk_read_back: assert property (
    (i_read && hit_dual_b) |=>
      o_rdata == $past(core_a_dual_input_b_offset_trim))
    else $error("read back mismatch");
  chk_no_side_write: assert property (
    (i_write && !hit_time && running)
      |=> $stable(core_b_single_input_b_time_trim))
    else $error("write disturbed other register");
  chk_read_one_cycle: assert property (
    !i_read |=> o_rdata == CTRB_RD_NONE)
    else $error("read data outside read slot");

endmodule
`default_nettype wire

// ===== tb/ctrb_tb_top.sv
`default_nettype none
module ctrb_tb_top
  import ctrb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                   i_clk, i_reset, i_write, i_read, i_fuse_valid;
  logic                   i_fg_cal_en, i_single_mode, i_phase_90;
  logic                   i_second_analog_input;
  logic [CTRB_ADDR_W-1:0] i_addr;
  logic [CTRB_DATA_W-1:0] i_wdata, o_rdata;
  logic [CTRB_TIME_W-1:0] o_time_trim;
  logic [CTRB_OFS_W-1:0]  o_offset_trim;
  logic                   o_time_trim_en, o_offset_trim_en, o_loaded;
  logic [15:0]            f [5];
  logic [15:0]            m [5];
  logic [11:0]            adr [5] = '{CTRB_OFS_TIME_B_SGL_B,
    CTRB_OFS_OFS_A_DUAL_A, CTRB_OFS_OFS_A_DUAL_B, CTRB_OFS_OFS_A_SGL_A,
    CTRB_OFS_OFS_A_SGL_B};
  integer                 seed = 32'he0a1;
  int                     fails, n_tests, k, i;
  logic [15:0]            d;

  ctrb_top u_dut (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read),
    .o_rdata(o_rdata), .i_fuse_valid(i_fuse_valid),
    .i_fuse_time_b_sgl_b(f[0][7:0]), .i_fuse_ofs_a_dual_a(f[1]),
    .i_fuse_ofs_a_dual_b(f[2]), .i_fuse_ofs_a_sgl_a(f[3]),
    .i_fuse_ofs_a_sgl_b(f[4]), .i_fg_cal_en(i_fg_cal_en),
    .i_single_mode(i_single_mode),
    .i_second_analog_input(i_second_analog_input),
    .i_phase_90(i_phase_90), .o_time_trim(o_time_trim),
    .o_time_trim_en(o_time_trim_en), .o_offset_trim(o_offset_trim),
    .o_offset_trim_en(o_offset_trim_en), .o_loaded(o_loaded));

  always #10 i_clk = ~i_clk;

  // One bus cycle; strobes last exactly one clock
  task automatic bus(input logic w, r, input logic [11:0] a,
                     input logic [15:0] dt);
    i_write <= w;
    i_read  <= r;
    i_addr  <= a;
    i_wdata <= dt;
    @(posedge i_clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      fails++;
    end
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [15:0] exp);
    bus(1'b0, 1'b1, a, 16'h0000);
    chk(o_rdata, exp);
  endtask

  task automatic wr(input int n, input logic [15:0] dt);
    bus(1'b1, 1'b0, adr[n], dt);
    m[n] = (n == 0) ? {8'h00, dt[7:0]} : dt;
  endtask

  // Offset select: {3'b000, enable, value}
  function automatic logic [15:0] exp_ofs(input logic [3:0] md);
    if (!md[3]) return 16'h0000;
    if (md[1] && md[0]) return {4'h1, m[4][11:0]};
    if (!md[1]) return {4'h1, m[md[2] ? 3 : 1][11:0]};
    if (!md[2]) return {4'h1, m[2][11:0]};
    return 16'h0000;
  endfunction

  task automatic stop_test;
    $display("counts: %0d compares, %0d mismatches", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #60000;
    fails++;
    stop_test();
  end

  initial begin
    i_clk = 1'b0; i_reset = 1'b1; i_write = 1'b0; i_read = 1'b0;
    i_addr = 12'h000; i_wdata = 16'h0000; i_fuse_valid = 1'b0;
    {i_fg_cal_en, i_single_mode, i_second_analog_input, i_phase_90} = 4'h0;
    for (k = 0; k < 5; k++) f[k] = 16'($random(seed));
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    #1;
    // Writes before the fuse load are dropped
    bus(1'b1, 1'b0, adr[1], 16'hFFFF);
    rd(adr[1], 16'h0000);
    i_fuse_valid <= 1'b1;
    for (k = 0; k < 10 && o_loaded !== 1'b1; k++) bus(1'b0, 1'b0, 0, 0);
    chk({15'h0000, o_loaded}, 16'h0001);
    for (k = 0; k < 5; k++) m[k] = (k == 0) ? {8'h00, f[0][7:0]} : f[k];
    for (k = 0; k < 5; k++) rd(adr[k], m[k]);
    $display("test fuse_load done");
    // All-ones corners first, then random back-to-back write and read
    for (i = 0; i < 40; i++) begin
      k = (i < 5) ? i : $unsigned($random(seed)) % 5;
      d = (i < 5) ? 16'hFFFF : 16'($random(seed));
      wr(k, d);
      rd(adr[k], m[k]);
    end
    bus(1'b1, 1'b0, 12'h34C, 16'hABCD);
    rd(12'h34C, 16'h0000);
    for (k = 0; k < 5; k++) rd(adr[k], m[k]);
    $display("test register_access done");
    // Every mode combination, with a fresh trim written each time
    for (i = 0; i < 16; i++) begin
      wr($unsigned($random(seed)) % 5, 16'($random(seed)));
      {i_fg_cal_en, i_single_mode, i_second_analog_input, i_phase_90}
        <= i[3:0];
      bus(1'b0, 1'b0, 0, 0);
      bus(1'b0, 1'b0, 0, 0);
      chk({3'b000, o_offset_trim_en, o_offset_trim},
          exp_ofs(i[3:0]));
      chk({7'h00, o_time_trim_en, o_time_trim},
          {7'h00, i[3] & i[2] & i[1], m[0][7:0]});
    end
    $display("test trim_select done");
    // Mid-run reset clears outputs; writes wait for a fresh fuse load
    i_reset      <= 1'b1;
    i_fuse_valid <= 1'b0;
    for (k = 0; k < 5; k++) f[k] <= 16'($random(seed));
    bus(1'b0, 1'b0, 12'h000, 16'h0000);
    chk({1'b0, o_loaded, o_time_trim_en, o_offset_trim_en, o_offset_trim},
        16'h0000);
    chk({8'h00, o_time_trim}, 16'h0000);
    i_reset <= 1'b0;
    bus(1'b1, 1'b0, adr[2], 16'h1234);
    rd(adr[2], 16'h0000);
    i_fuse_valid <= 1'b1;
    bus(1'b0, 1'b0, 12'h000, 16'h0000);
    bus(1'b0, 1'b0, 12'h000, 16'h0000);
    for (k = 0; k < 5; k++) m[k] = (k == 0) ? {8'h00, f[0][7:0]} : f[k];
    for (k = 0; k < 5; k++) rd(adr[k], m[k]);
    $display("test mid_reset done");
    stop_test();
  end
endmodule
`default_nettype wire
